//--- common/fmc_pkg.sv
package fmc_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_RAM_OVERLAY_CONTROL    = 16'hfedb;
   localparam logic [15:0] IDX_SYSTEM_CONTROL_TWO     = 16'hff42;
   localparam logic [15:0] IDX_FLASH_CONTROL_ONE      = 16'hff80;
   localparam logic [15:0] IDX_FLASH_CONTROL_TWO      = 16'hff81;
   localparam logic [15:0] IDX_ERASE_BLOCK_SELECT_ONE = 16'hff82;
   localparam logic [15:0] IDX_ERASE_BLOCK_SELECT_TWO = 16'hff83;

   localparam int FC1_WEP_BIT = 7;
   localparam int FC1_SWE_BIT = 6;
   localparam int FC1_EV_BIT  = 3;
   localparam int FC1_PV_BIT  = 2;
   localparam int FC1_E_BIT   = 1;
   localparam int FC1_P_BIT   = 0;
   localparam int FC2_ERR_BIT = 7;
   localparam int FC2_ESU_BIT = 1;
   localparam int FC2_PSU_BIT = 0;
   localparam int SC2_FRS_BIT = 3;
   localparam int ROC_OVS_BIT = 3;
   localparam int ROC_BLK_LSB = 0;

   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam logic [7:0] FC1_RESET_HI  = 8'h80;
   localparam logic [7:0] ERASED_BYTE   = 8'hff;
   localparam logic [7:0] SC2_NO_FLASH  = 8'h00;
   localparam int         PROG_BYTES    = 32;
   localparam int         N_BLOCKS      = 10;
   localparam logic [9:0] ALL_BLOCKS    = 10'h3ff;
   localparam logic [3:0] SUB_LAST      = 4'h8;
   localparam logic [2:0] HSIZE_BYTE    = 3'h0;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   typedef enum logic [2:0] {
      MODE_DISABLED   = 3'b000,
      MODE_USER       = 3'b001,
      MODE_USER_PROG  = 3'b010,
      MODE_BOOT       = 3'b011,
      MODE_PROGRAMMER = 3'b100
   } fmc_mode_t;

   typedef enum logic [2:0] {
      REG_NONE = 3'b000,
      REG_ROC  = 3'b001,
      REG_SC2  = 3'b010,
      REG_FC1  = 3'b011,
      REG_FC2  = 3'b100,
      REG_EB1  = 3'b101,
      REG_EB2  = 3'b110
   } fmc_reg_t;

   typedef enum logic [1:0] {
      BAUD_IDLE    = 2'b00,
      BAUD_WAIT    = 2'b01,
      BAUD_MEASURE = 2'b10,
      BAUD_LOCKED  = 2'b11
   } fmc_baud_t;
endpackage

//--- logic/fmc_top.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// - programming writes one 32-byte row at once.
// - array split in ten blocks: 2x32k, 2x8k, 16k, 28k, 4x1k.
// - four array modes: program, erase, program-verify, erase-verify.
// - mode taken from mode pins and write-enable pin at reset release.
// - plain user mode reads only; program and erase have no effect.
// - program and erase only in boot, user program and programmer modes.
// - boot erases whole array to 0xff; block erase only in user program mode.
// - boot mode serial receiver measures host bit rate automatically.
// - overlay active makes reads of the chosen block come from overlay RAM.
// - clearing overlay select returns that block to the flash array.
// - hardware, software and error protection block program and erase.
// - flash registers reachable only with select bit set; overlay register always.
// - flash disabled: flash registers read 0x00, writes ignored.
// - flash register writes blocked while write-enable status bit is 0.
// - first control register resets to 0x80 with pin high, else 0x00.
// - second control (except its error flag) and erase block registers held 0 unless pin and enable set.
// - flash registers byte wide, each access two states.
// - without flash, select register ignores writes, reads a fixed value.
// - write-enable status bit mirrors the pin; low means hardware protected.
// - program entry order: enable, then setup, then program bit.
// - error flag set enters error protection, no more program or erase.
module fmc_top #(
   parameter bit         HAS_FLASH = 1'b1,
   parameter logic [7:0] SC2_UNDEF = fmc_pkg::SC2_NO_FLASH
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              write_enable_pin,
   input  wire logic              mode_pin_two,
   input  wire logic              mode_pin_one,
   input  wire logic              mode_pin_zero,
   input  wire logic              serial_rx_line,
   output logic                   serial_tx_line,
   input  wire logic              flash_wr_valid,
   input  wire logic [16:0]       flash_wr_addr,
   input  wire logic [7:0]        flash_wr_data,
   input  wire logic [16:0]       flash_rd_addr,
   input  wire logic              array_fault,
   output logic                   overlay_hit,
   output logic                   array_prog,
   output logic      [11:0]       array_prog_row,
   output logic      [255:0]      array_prog_data,
   output logic                   array_erase,
   output logic                   array_erase_all,
   output logic      [9:0]        array_erase_mask,
   output logic                   array_prog_verify,
   output logic                   array_erase_verify,
   output fmc_pkg::fmc_mode_t     op_mode,
   output logic      [15:0]       baud_bit_cycles,
   output logic                   baud_locked
);
   import fmc_pkg::*;

   function automatic fmc_reg_t reg_of(input logic [31:0] a);
      fmc_reg_t r;
      r = REG_NONE;
      if (a[31:18] == 14'h0000 && a[1:0] == 2'h0) begin
         case (a[17:2])
            IDX_RAM_OVERLAY_CONTROL:    r = REG_ROC;
            IDX_SYSTEM_CONTROL_TWO:     r = REG_SC2;
            IDX_FLASH_CONTROL_ONE:      r = REG_FC1;
            IDX_FLASH_CONTROL_TWO:      r = REG_FC2;
            IDX_ERASE_BLOCK_SELECT_ONE: r = REG_EB1;
            IDX_ERASE_BLOCK_SELECT_TWO: r = REG_EB2;
            default:                    r = REG_NONE;
         endcase
      end
      return r;
   endfunction

   // block map: four 1k at the bottom, then 28k, 16k, 8k, 8k, 32k, 32k
   function automatic logic [3:0] block_of(input logic [16:0] a);
      logic [3:0] b;
      b = 4'h0;
      if (a < 17'h01000) begin
         b = {2'b00, a[11:10]};
      end else if (a < 17'h08000) begin
         b = 4'h4;
      end else if (a < 17'h0c000) begin
         b = 4'h5;
      end else if (a < 17'h0e000) begin
         b = 4'h6;
      end else if (a < 17'h10000) begin
         b = 4'h7;
      end else if (a < 17'h18000) begin
         b = 4'h8;
      end else begin
         b = 4'h9;
      end
      return b;
   endfunction

   function automatic fmc_mode_t mode_of(input logic [2:0] md, input logic wep);
      fmc_mode_t m;
      if (!md[2]) begin
         m = MODE_DISABLED;
      end else if (!wep) begin
         m = MODE_USER;
      end else begin
         case (md[1:0])
            2'b00:   m = MODE_BOOT;
            2'b11:   m = MODE_PROGRAMMER;
            default: m = MODE_USER_PROG;
         endcase
      end
      return m;
   endfunction

   logic        rst_meta_r;
   logic        rst_n_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   fmc_mode_t   mode_r, mode_nxt;
   fmc_reg_t    dp_reg_r, dp_reg_nxt;
   fmc_baud_t   baud_st_r, baud_st_nxt;
   logic        mode_lat_r, mode_lat_nxt;
   logic        wep_r, wep_nxt;
   logic        dp_r, dp_nxt;
   logic        dp_wr_r, dp_wr_nxt;
   logic        dp_sz_ok_r, dp_sz_ok_nxt;
   logic        hro_r, hro_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic        frs_r, frs_nxt;
   logic        ovs_r, ovs_nxt;
   logic [1:0]  ovl_blk_r, ovl_blk_nxt;
   logic        swe_r, swe_nxt;
   logic        ev_r, ev_nxt;
   logic        pv_r, pv_nxt;
   logic        e_r, e_nxt;
   logic        p_r, p_nxt;
   logic        esu_r, esu_nxt;
   logic        psu_r, psu_nxt;
   logic        err_r, err_nxt;
   logic [9:0]  eb_r, eb_nxt;
   logic        ers_r, ers_nxt;
   logic        ers_all_r, ers_all_nxt;
   logic [9:0]  ers_mask_r, ers_mask_nxt;
   logic [255:0] buf_r, buf_nxt;
   logic [11:0] row_r, row_nxt;
   logic        ovl_hit_r, ovl_hit_nxt;
   logic [3:0]  sub_r, sub_nxt;
   logic [15:0] bcnt_r, bcnt_nxt;
   logic [15:0] baud_r, baud_nxt;
   logic        lck_r, lck_nxt;

   logic        flash_on;
   logic        pe_mode;
   logic        blk_mode;
   logic        fwr;
   logic [7:0]  wd;
   logic [9:0]  wr_blk_hot;

   always_comb begin
      mode_nxt     = mode_r;
      mode_lat_nxt = 1'b1;
      wep_nxt      = write_enable_pin;
      dp_nxt       = dp_r;
      dp_reg_nxt   = dp_reg_r;
      dp_wr_nxt    = dp_wr_r;
      dp_sz_ok_nxt = dp_sz_ok_r;
      hro_nxt      = hro_r;
      rdata_nxt    = rdata_r;
      frs_nxt      = frs_r;
      ovs_nxt      = ovs_r;
      ovl_blk_nxt  = ovl_blk_r;
      swe_nxt      = swe_r;
      ev_nxt       = ev_r;
      pv_nxt       = pv_r;
      e_nxt        = e_r;
      p_nxt        = p_r;
      esu_nxt      = esu_r;
      psu_nxt      = psu_r;
      eb_nxt       = eb_r;
      buf_nxt      = buf_r;
      row_nxt      = row_r;
      baud_st_nxt  = baud_st_r;
      sub_nxt      = sub_r;
      bcnt_nxt     = bcnt_r;
      baud_nxt     = baud_r;
      wd           = hwdata[7:0];
      wr_blk_hot   = 10'h000;
      wr_blk_hot[block_of(flash_wr_addr)] = 1'b1;

      // pins are caught on the first edge after the reset copy releases
      if (!mode_lat_r) begin
         mode_nxt = mode_of({mode_pin_two, mode_pin_one, mode_pin_zero}, write_enable_pin);
      end

      flash_on = HAS_FLASH && (mode_r != MODE_DISABLED) && frs_r;
      pe_mode  = (mode_r == MODE_BOOT) || (mode_r == MODE_USER_PROG) || (mode_r == MODE_PROGRAMMER);
      blk_mode = (mode_r == MODE_USER_PROG);

      // every register takes one wait state, so a flash register access is two states
      if (dp_r) begin
         dp_nxt  = 1'b0;
         hro_nxt = 1'b1;
         fwr     = dp_wr_r && dp_sz_ok_r && flash_on && wep_r;
         case (dp_reg_r)
            REG_ROC: begin
               rdata_nxt = 8'h00;
               rdata_nxt[ROC_OVS_BIT] = ovs_r;
               rdata_nxt[ROC_BLK_LSB +: 2] = ovl_blk_r;
               if (dp_wr_r) begin
                  ovs_nxt     = wd[ROC_OVS_BIT];
                  ovl_blk_nxt = wd[ROC_BLK_LSB +: 2];
               end
            end
            REG_SC2: begin
               rdata_nxt = 8'h00;
               rdata_nxt[SC2_FRS_BIT] = frs_r;
               if (!HAS_FLASH) begin
                  rdata_nxt = SC2_UNDEF;
               end else if (dp_wr_r) begin
                  frs_nxt = wd[SC2_FRS_BIT];
               end
            end
            REG_FC1: begin
               rdata_nxt = {wep_r, swe_r, 2'b00, ev_r, pv_r, e_r, p_r};
               if (fwr) begin
                  swe_nxt = wd[FC1_SWE_BIT];
                  if (swe_r) begin
                     ev_nxt = wd[FC1_EV_BIT];
                     pv_nxt = wd[FC1_PV_BIT];
                     e_nxt  = wd[FC1_E_BIT] && esu_r;
                     p_nxt  = wd[FC1_P_BIT] && psu_r;
                  end
               end
            end
            REG_FC2: begin
               rdata_nxt = {err_r, 5'h00, esu_r, psu_r};
               if (fwr && swe_r) begin
                  esu_nxt = wd[FC2_ESU_BIT];
                  psu_nxt = wd[FC2_PSU_BIT];
               end
            end
            REG_EB1: begin
               rdata_nxt = {6'h00, eb_r[9:8]};
               if (fwr && swe_r) begin
                  eb_nxt[9:8] = wd[1:0];
               end
            end
            REG_EB2: begin
               rdata_nxt = eb_r[7:0];
               if (fwr && swe_r) begin
                  eb_nxt[7:0] = wd;
               end
            end
            default: rdata_nxt = 8'h00;
         endcase
         if (!flash_on && dp_reg_r != REG_ROC && dp_reg_r != REG_SC2) begin
            rdata_nxt = REG_RESET;
         end
      end else begin
         fwr = 1'b0;
      end

      if (hsel && hready && htrans[1]) begin
         dp_nxt       = 1'b1;
         hro_nxt      = 1'b0;
         dp_reg_nxt   = reg_of(haddr);
         dp_wr_nxt    = hwrite;
         dp_sz_ok_nxt = (hsize == HSIZE_BYTE) || (hsize == HSIZE_WORD);
      end

      // protection chain, strongest first
      if (!wep_r) begin
         swe_nxt = 1'b0;
      end
      if (!swe_nxt) begin
         {ev_nxt, pv_nxt, e_nxt, p_nxt, esu_nxt, psu_nxt} = 6'h00;
         eb_nxt = 10'h000;
      end
      if (err_r || !pe_mode) begin
         e_nxt = 1'b0;
         p_nxt = 1'b0;
      end

      // writing the array while it is being programmed, or a block while it is being erased, is an error
      err_nxt = err_r || array_fault || (flash_wr_valid && p_r) ||
                (flash_wr_valid && ers_r && (ers_all_r || (wr_blk_hot & ers_mask_r) != 10'h000));

      // one erase at a time; more than one selected block starts nothing
      ers_mask_nxt = blk_mode ? eb_nxt : ALL_BLOCKS;
      ers_all_nxt  = e_nxt && !blk_mode;
      ers_nxt      = e_nxt && (!blk_mode || $onehot(eb_nxt));

      // row latch collects bytes between setup and program; unwritten bytes stay erased
      if (flash_wr_valid && psu_r && !p_r && pe_mode && !err_r) begin
         buf_nxt[flash_wr_addr[4:0]*8 +: 8] = flash_wr_data;
         row_nxt = flash_wr_addr[16:5];
      end
      if (p_r && !p_nxt) begin
         buf_nxt = {PROG_BYTES{ERASED_BYTE}};
      end

      ovl_hit_nxt = ovs_nxt && (block_of(flash_rd_addr) == {2'b00, ovl_blk_nxt});

      // host sends a zero byte: nine bit times low, so count in ninths
      case (baud_st_r)
         BAUD_IDLE: begin
            if (mode_r == MODE_BOOT && mode_lat_r) begin
               baud_st_nxt = BAUD_WAIT;
            end
         end
         BAUD_WAIT: begin
            sub_nxt  = 4'h0;
            bcnt_nxt = 16'h0000;
            if (!serial_rx_line) begin
               baud_st_nxt = BAUD_MEASURE;
            end
         end
         BAUD_MEASURE: begin
            if (serial_rx_line) begin
               baud_nxt    = bcnt_r;
               baud_st_nxt = BAUD_LOCKED;
            end else if (sub_r == SUB_LAST) begin
               sub_nxt  = 4'h0;
               bcnt_nxt = bcnt_r + 16'h0001;
            end else begin
               sub_nxt = sub_r + 4'h1;
            end
         end
         BAUD_LOCKED: baud_st_nxt = BAUD_LOCKED;
         default:     baud_st_nxt = BAUD_IDLE;
      endcase
      lck_nxt = (baud_st_nxt == BAUD_LOCKED);
   end

   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mode_r     <= MODE_DISABLED;
         mode_lat_r <= 1'b0;
         wep_r      <= 1'b0;
         dp_r       <= 1'b0;
         dp_reg_r   <= REG_NONE;
         dp_wr_r    <= 1'b0;
         dp_sz_ok_r <= 1'b0;
         hro_r      <= 1'b1;
         rdata_r    <= REG_RESET;
         frs_r      <= 1'b0;
         ovs_r      <= 1'b0;
         ovl_blk_r  <= 2'h0;
         swe_r      <= 1'b0;
         ev_r       <= 1'b0;
         pv_r       <= 1'b0;
         e_r        <= 1'b0;
         p_r        <= 1'b0;
         esu_r      <= 1'b0;
         psu_r      <= 1'b0;
         err_r      <= 1'b0;
         eb_r       <= 10'h000;
         ers_r      <= 1'b0;
         ers_all_r  <= 1'b0;
         ers_mask_r <= 10'h000;
         buf_r      <= {PROG_BYTES{ERASED_BYTE}};
         row_r      <= 12'h000;
         ovl_hit_r  <= 1'b0;
         baud_st_r  <= BAUD_IDLE;
         sub_r      <= 4'h0;
         bcnt_r     <= 16'h0000;
         baud_r     <= 16'h0000;
         lck_r      <= 1'b0;
      end else begin
         mode_r     <= mode_nxt;
         mode_lat_r <= mode_lat_nxt;
         wep_r      <= wep_nxt;
         dp_r       <= dp_nxt;
         dp_reg_r   <= dp_reg_nxt;
         dp_wr_r    <= dp_wr_nxt;
         dp_sz_ok_r <= dp_sz_ok_nxt;
         hro_r      <= hro_nxt;
         rdata_r    <= rdata_nxt;
         frs_r      <= frs_nxt;
         ovs_r      <= ovs_nxt;
         ovl_blk_r  <= ovl_blk_nxt;
         swe_r      <= swe_nxt;
         ev_r       <= ev_nxt;
         pv_r       <= pv_nxt;
         e_r        <= e_nxt;
         p_r        <= p_nxt;
         esu_r      <= esu_nxt;
         psu_r      <= psu_nxt;
         err_r      <= err_nxt;
         eb_r       <= eb_nxt;
         ers_r      <= ers_nxt;
         ers_all_r  <= ers_all_nxt;
         ers_mask_r <= ers_mask_nxt;
         buf_r      <= buf_nxt;
         row_r      <= row_nxt;
         ovl_hit_r  <= ovl_hit_nxt;
         baud_st_r  <= baud_st_nxt;
         sub_r      <= sub_nxt;
         bcnt_r     <= bcnt_nxt;
         baud_r     <= baud_nxt;
         lck_r      <= lck_nxt;
      end
   end

   assign hrdata             = {24'h000000, rdata_r};
   assign hreadyout          = hro_r;
   assign hresp              = 1'b0;
   assign serial_tx_line     = rst_n_r; // idle high, transmit path lives elsewhere
   assign overlay_hit        = ovl_hit_r;
   assign array_prog         = p_r;
   assign array_prog_row     = row_r;
   assign array_prog_data    = buf_r;
   assign array_erase        = ers_r;
   assign array_erase_all    = ers_all_r;
   assign array_erase_mask   = ers_mask_r;
   assign array_prog_verify  = pv_r;
   assign array_erase_verify = ev_r;
   assign op_mode            = mode_r;
   assign baud_bit_cycles    = baud_r;
   assign baud_locked        = lck_r;

endmodule

//--- test/flash_mode_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; $display("wrong value %0t %h %h", $time, (a), (e)); end end
module flash_mode_control_tb_top;
   import fmc_pkg::*;
   localparam logic [15:0] FC1 = IDX_FLASH_CONTROL_ONE;
   localparam logic [15:0] FC2 = IDX_FLASH_CONTROL_TWO;
   localparam logic [15:0] EB1 = IDX_ERASE_BLOCK_SELECT_ONE;
   localparam logic [15:0] EB2 = IDX_ERASE_BLOCK_SELECT_TWO;
   localparam logic [15:0] SC2 = IDX_SYSTEM_CONTROL_TWO;
   localparam logic [15:0] ROC = IDX_RAM_OVERLAY_CONTROL;
   logic         core_clk = 1'b0;
   logic         nrst = 1'b0;
   logic         hsel, hwrite, rdy, hresp, tmo, fwv, fault, hit, aprog, aerase, aall, apv, aev, lck, wen, rx, tx;
   logic [1:0]   htrans;
   logic [2:0]   md, hsize;
   logic [7:0]   fwd;
   logic [9:0]   mask;
   logic [11:0]  row;
   logic [15:0]  bcyc;
   logic [16:0]  fwa, fra;
   logic [31:0]  haddr, hwdata, hrdata;
   logic [255:0] pdata;
   fmc_mode_t    mode;
   int           errors = 0;
   int           n_checks = 0;

   always #5 core_clk = ~core_clk;

   fmc_top u_dut (
      .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
      .write_enable_pin(wen), .mode_pin_two(md[2]), .mode_pin_one(md[1]), .mode_pin_zero(md[0]),
      .serial_rx_line(rx), .serial_tx_line(tx), .flash_wr_valid(fwv), .flash_wr_addr(fwa),
      .flash_wr_data(fwd), .flash_rd_addr(fra), .array_fault(fault), .overlay_hit(hit),
      .array_prog(aprog), .array_prog_row(row), .array_prog_data(pdata), .array_erase(aerase),
      .array_erase_all(aall), .array_erase_mask(mask), .array_prog_verify(apv),
      .array_erase_verify(aev), .op_mode(mode), .baud_bit_cycles(bcyc), .baud_locked(lck));
   fmc_cpu_bfm u_cpu (.core_clk(core_clk), .hready(rdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .tmo(tmo));

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge tmo) begin
      errors++;
      finish_test();
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      logic [31:0] r;
      u_cpu.xfer(1'b1, {14'h0, i, 2'b00}, {24'h0, d}, r);
      #1;
   endtask
   task automatic rd(input logic [15:0] i, output logic [7:0] d);
      logic [31:0] r;
      u_cpu.xfer(1'b0, {14'h0, i, 2'b00}, 32'h0, r);
      d = r[7:0];
   endtask
   task automatic rchk(input logic [15:0] i, input logic [7:0] e);
      logic [7:0] d;
      rd(i, d);
      `CHK(d, e)
   endtask
   task automatic do_reset(input logic [2:0] m, input logic w);
      @(posedge core_clk);
      nrst <= 1'b0;
      md   <= m;
      wen  <= w;
      cyc(16);
      @(posedge core_clk) nrst <= 1'b1;
      cyc(6);
   endtask
   task automatic t_regs();
      rchk(FC1, 8'h00);
      wr(ROC, 8'h03);
      rchk(ROC, 8'h03);
      wr(SC2, 8'h08);
      rchk(FC1, 8'h80);
      rchk(FC2, 8'h00);
      rchk(EB1, 8'h00);
      wr(EB2, 8'hff);
      rchk(EB2, 8'h00);
      rchk(16'hff84, 8'h00);
      `CHK({hresp, tx}, 2'b01)
      @(posedge core_clk) wen <= 1'b0;
      wr(FC1, 8'h40);
      rchk(FC1, 8'h00);
      @(posedge core_clk) wen <= 1'b1;
      rchk(FC1, 8'h80);
   endtask
   task automatic t_prog();
      logic [255:0] exp;
      wr(FC1, 8'h41);
      rchk(FC1, 8'hc0);
      wr(FC1, 8'h44);
      `CHK(apv, 1'b1)
      wr(FC1, 8'h48);
      `CHK({aev, apv}, 2'b10)
      wr(FC1, 8'h40);
      wr(FC2, 8'h01);
      for (int i = 0; i < 32; i++) begin
         @(posedge core_clk);
         fwv <= 1'b1;
         fwa <= 17'h00a40 + 17'(i);
         fwd <= 8'(i) ^ 8'h5a;
         exp[8*i +: 8] = 8'(i) ^ 8'h5a;
      end
      @(posedge core_clk) fwv <= 1'b0;
      wr(FC1, 8'h41);
      `CHK({aprog, row}, 13'h1052)
      `CHK(pdata, exp)
      wr(FC1, 8'h40);
      wr(FC2, 8'h02);
      wr(EB2, 8'h05);
      wr(FC1, 8'h42);
      cyc(2);
      `CHK(aerase, 1'b0)
      wr(EB2, 8'h04);
      cyc(2);
      `CHK({aerase, aall, mask}, 12'h804)
      wr(FC1, 8'h40);
   endtask
   task automatic t_ovl_fault();
      logic [7:0] d;
      wr(ROC, 8'h0a);
      @(posedge core_clk) fra <= 17'h00800;
      cyc(2);
      `CHK(hit, 1'b1)
      @(posedge core_clk) fra <= 17'h00400;
      cyc(2);
      `CHK(hit, 1'b0)
      wr(ROC, 8'h02);
      @(posedge core_clk) fra <= 17'h00800;
      cyc(2);
      `CHK(hit, 1'b0)
      @(posedge core_clk) fault <= 1'b1;
      @(posedge core_clk) fault <= 1'b0;
      rd(FC2, d);
      `CHK(d[7], 1'b1)
      wr(FC1, 8'h42);
      cyc(2);
      `CHK(aerase, 1'b0)
   endtask
   task automatic t_modes();
      logic [3:0] pins [5] = '{4'b0011, 4'b1010, 4'b1011, 4'b1001, 4'b1111};
      fmc_mode_t  em [5] = '{MODE_DISABLED, MODE_USER, MODE_USER_PROG, MODE_BOOT, MODE_PROGRAMMER};
      for (int k = 0; k < 5; k++) begin
         do_reset(pins[k][3:1], pins[k][0]);
         `CHK(mode, em[k])
         wr(SC2, 8'h08);
         rchk(FC1, {pins[k][0] & (k != 0), 7'h0});
         @(posedge core_clk) wen <= 1'b1;
         if (em[k] == MODE_BOOT) begin
            @(posedge core_clk) rx <= 1'b0;
            cyc(90);
            @(posedge core_clk) rx <= 1'b1;
            cyc(4);
            `CHK({lck, bcyc}, 17'h1000a)
         end
         wr(FC1, 8'h40);
         wr(FC2, 8'h02);
         wr(EB1, 8'h01);
         wr(FC1, 8'h42);
         cyc(2);
         `CHK(aerase, 1'(k > 1))
         if (k > 1) `CHK(mask, em[k] == MODE_USER_PROG ? 10'h100 : ALL_BLOCKS)
      end
   endtask

   initial begin
      {fwv, fault, fwa, fwd, fra} = '0;
      md  = 3'b101;
      wen = 1'b1;
      rx  = 1'b1;
      do_reset(3'b101, 1'b1);
      t_regs();
      t_prog();
      t_ovl_fault();
      t_modes();
      finish_test();
   end
endmodule

//--- test/fmc_chk.sv
`timescale 1ns/1ps
module fmc_chk (
   input wire logic               core_clk,
   input wire logic               nrst,
   input wire logic               hsel,
   input wire logic [1:0]         htrans,
   input wire logic               hready,
   input wire logic               hreadyout,
   input wire logic               array_fault,
   input wire logic               array_prog,
   input wire logic               array_erase,
   input wire logic               array_erase_all,
   input wire logic [9:0]         array_erase_mask,
   input wire fmc_pkg::fmc_mode_t op_mode
);
   import fmc_pkg::*;
   logic [2:0] flt_r;
   logic [2:0] flt_nxt;
   logic [2:0] age_r;
   logic [2:0] age_nxt;

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // fault history: the error flag gets two cycles to land before it must block
   always_comb begin
      flt_nxt = {flt_r[1:0], flt_r[0] | array_fault};
      age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         flt_r <= 3'h0;
         age_r <= 3'h0;
      end else begin
         flt_r <= flt_nxt;
         age_r <= age_nxt;
      end
   end

   a_one_wait_state: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
      else $error("register access not two cycles");
   a_prog_mode_only: assert property (
      array_prog |-> op_mode inside {MODE_USER_PROG, MODE_BOOT, MODE_PROGRAMMER})
      else $error("program outside a programming mode");
   a_erase_mode_only: assert property (
      array_erase |-> op_mode inside {MODE_USER_PROG, MODE_BOOT, MODE_PROGRAMMER})
      else $error("erase outside a programming mode");
   a_user_read_only: assert property (op_mode == MODE_USER |-> !array_prog && !array_erase)
      else $error("array operation in user mode");
   a_boot_whole_erase: assert property (
      array_erase && op_mode == MODE_BOOT |-> array_erase_all && array_erase_mask == ALL_BLOCKS)
      else $error("boot erase not whole array");
   a_one_block_erase: assert property (
      array_erase && op_mode == MODE_USER_PROG |-> $onehot(array_erase_mask) && !array_erase_all)
      else $error("user program erase not one block");
   a_error_blocks_ops: assert property (flt_r[2] |-> !array_prog && !array_erase)
      else $error("operation after array fault");
   a_mode_held: assert property (age_r == 3'h7 |-> $stable(op_mode))
      else $error("mode changed after reset");
endmodule

bind fmc_top fmc_chk u_chk (
   .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hreadyout(hreadyout), .array_fault(array_fault), .array_prog(array_prog),
   .array_erase(array_erase), .array_erase_all(array_erase_all),
   .array_erase_mask(array_erase_mask), .op_mode(op_mode)
);

//--- test/fmc_cpu_bfm.sv
`timescale 1ns/1ps
module fmc_cpu_bfm (
   input  wire logic        core_clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   output logic             tmo
);
   import fmc_pkg::*;
   logic        rdy_s;
   logic [31:0] rd_s;

   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, tmo} = '0;
      hsize = HSIZE_WORD;
   end
   // settled copies, so the sampling edge never races the slave's flops
   always @(negedge core_clk) begin
      rdy_s <= hready;
      rd_s  <= hrdata;
   end
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!rdy_s && n < 40);
      if (!rdy_s)
         tmo <= 1'b1;
   endtask
   task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= we;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      hsel   <= 1'b0;
      rd = rd_s;
   endtask
endmodule
